// [hw/pmu_seq_pkg.sv]
// Constants, input positions and mode encoding for the LED supply mode sequencer.
package pmu_seq_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SAVE_DWELL_NS = 10000;
    localparam int IDLE_TIMEOUT_NS = 100000;
    localparam int CNT_W = 12;
    // Least dwell rounds up, the timeout rounds down.
    localparam logic [CNT_W-1:0] SAVE_DWELL_CYC =
        CNT_W'((SAVE_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] IDLE_TIMEOUT_CYC = CNT_W'(IDLE_TIMEOUT_NS / CLK_PERIOD_NS);

    // ----------------------------------------
    // Synchronised input vector positions
    // ----------------------------------------
    localparam int IN_W = 14;
    localparam int IN_TURN_ON = 0;
    localparam int IN_SAVE_LOW = 1;
    localparam int IN_REF_OFF = 2;
    localparam int IN_TURN_OFF = 3;
    localparam int IN_REG_START = 4;
    localparam int IN_REG_ON = 5;
    localparam int IN_REG_OFF = 6;
    localparam int IN_REF_OK = 7;
    localparam int IN_REF_LOW = 8;
    localparam int IN_CS_TRIP = 9;
    localparam int IN_LOW = 10;
    localparam int IN_HIGH = 11;
    localparam int IN_PFC = 12;
    localparam int IN_AUX = 13;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int CTRL_INHIBIT_BIT = 0;
    localparam logic CTRL_INHIBIT_RST = 1'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {MODE_STARTUP, MODE_SAVE, MODE_OPER, MODE_SHUTDOWN} mode_e;

endpackage

// [hw/pin_sync.sv]
// Two flip-flop synchroniser for a vector of pin levels.
`timescale 1ns/100ps
module pin_sync
(
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [pmu_seq_pkg::IN_W-1:0] din,
    output      logic [pmu_seq_pkg::IN_W-1:0] dout
);
    import pmu_seq_pkg::*;

    logic [IN_W-1:0] stage1;

    // ----------------------------------------
    // Sync chain
    // ----------------------------------------
    // First stage feeds only the second stage.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage1 <= '0;
            dout   <= '0;
        end
        else
        begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule // pin_sync

// [hw/led_pmu_seq.sv]
// Mode sequencer, regulator switch, overcurrent latch and gate drivers with an AXI4-Lite slave.
// What this block does
// - Startup: generator on, reference sink on, everything else disabled.
// - Supply above turn-on in startup stops generator, goes to save.
// - Save: low-current reference, generator cycles between thresholds, rest disabled.
// - Save: supply below reference-off returns to startup.
// - Operating needs 10 us in save, reference above 3.0 V, high-input fall.
// - Operating: generator off, high-current reference, regulator, protection, drivers on.
// - Operating: low input idle over 100 us returns to save.
// - Operating: supply below turn-off or reference below 2.0 V enters shutdown.
// - Shutdown: generator on, low-current reference, the rest disabled.
// - Shutdown: turn-on goes to save; below reference-off goes to startup.
// - Regulator active and supply above start closes the switch at once.
// - Supply between on and start closes switch at next low-input fall.
// - Supply below regulator-off opens switch at next low-input fall.
// - Reference enabled only above reference-off; otherwise the sink is on.
// - Input monitor holds every driver low during startup.
// - Current trip latches fault, forces half-bridge gates low, flag high.
// - Fault holds until both half-bridge inputs low and current below trip.
// - Both half-bridge inputs high force both half-bridge gates low.
// - Bootstrap switch follows low gate; never conducts back into supply.
// - Enabled drivers follow their own logic inputs.
// - Overcurrent protection runs beside the sequencer, enabled only when operating.
// - Inactivity timeout lies between 70 and 130 us.
`timescale 1ns/100ps
module led_pmu_seq
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        supply_turn_on_thr,
    input  wire logic        supply_save_low_thr,
    input  wire logic        supply_ref_off_thr,
    input  wire logic        supply_turn_off_thr,
    input  wire logic        regulator_start_thr,
    input  wire logic        regulator_on_thr,
    input  wire logic        regulator_off_thr,
    input  wire logic        ref_above_enable,
    input  wire logic        ref_below_latch,
    input  wire logic        current_sense_trip,
    input  wire logic        low_side_logic_in,
    input  wire logic        high_side_logic_in,
    input  wire logic        pfc_logic_in,
    input  wire logic        aux_logic_in,
    output      logic        hv_startup_gen,
    output      logic        ref_enable,
    output      logic        ref_high_current,
    output      logic        ref_sink_enable,
    output      logic        regulator_switch,
    output      logic        overcurrent_flag_out,
    output      logic        low_side_gate_out,
    output      logic        high_side_gate_out,
    output      logic        pfc_gate_out,
    output      logic        aux_gate_out,
    output      logic        bootstrap_switch
);
    import pmu_seq_pkg::*;

    logic [IN_W-1:0]  pins;
    mode_e            mode;
    mode_e            next_mode;
    logic [CNT_W-1:0] save_cnt;
    logic [CNT_W-1:0] idle_cnt;
    logic             low_prev;
    logic             high_prev;
    logic             low_fall;
    logic             high_fall;
    logic             low_edge;
    logic             fault;
    logic             inhibit;
    logic             drv_en;
    logic             hb_block;
    logic             aw_got;
    logic             w_got;
    logic [3:0]       aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;

    // ----------------------------------------
    // Input conditioning
    // ----------------------------------------
    // synchronised comparator bits
    pin_sync u_sync
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     ({aux_logic_in, pfc_logic_in, high_side_logic_in, low_side_logic_in,
                   current_sense_trip, ref_below_latch, ref_above_enable, regulator_off_thr,
                   regulator_on_thr, regulator_start_thr, supply_turn_off_thr,
                   supply_ref_off_thr, supply_save_low_thr, supply_turn_on_thr}),
        .dout    (pins)
    );

    // Edge history of the two half-bridge inputs.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            low_prev  <= 1'b0;
            high_prev <= 1'b0;
        end
        else
        begin
            low_prev  <= pins[IN_LOW];
            high_prev <= pins[IN_HIGH];
        end
    end

    // Edge decodes used by the sequencer and the regulator.
    assign low_fall  = low_prev & ~pins[IN_LOW];
    assign high_fall = high_prev & ~pins[IN_HIGH];
    assign low_edge  = low_prev ^ pins[IN_LOW];

    // ----------------------------------------
    // Mode sequencer
    // ----------------------------------------
    // Next mode from the current mode and the comparator levels.
    always_comb
    begin
        next_mode = mode;
        case (mode)
            MODE_STARTUP:
            begin
                if (pins[IN_TURN_ON])
                    next_mode = MODE_SAVE;
            end
            MODE_SAVE:
            begin
                if (pins[IN_REF_OFF])
                    next_mode = MODE_STARTUP;
                else if (save_cnt >= SAVE_DWELL_CYC && pins[IN_REF_OK] && high_fall)
                    next_mode = MODE_OPER;
            end
            MODE_OPER:
            begin
                if (pins[IN_TURN_OFF] || pins[IN_REF_LOW])
                    next_mode = MODE_SHUTDOWN;
                else if (idle_cnt >= IDLE_TIMEOUT_CYC)
                    next_mode = MODE_SAVE;
            end
            MODE_SHUTDOWN:
            begin
                if (pins[IN_REF_OFF])
                    next_mode = MODE_STARTUP;
                else if (pins[IN_TURN_ON])
                    next_mode = MODE_SAVE;
            end
            default:
                next_mode = MODE_STARTUP;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mode <= MODE_STARTUP;
        else
            mode <= next_mode;
    end

    // Save-mode dwell counter; saturates once the dwell has passed.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            save_cnt <= '0;
        else if (mode != MODE_SAVE)
            save_cnt <= '0;
        else if (save_cnt < SAVE_DWELL_CYC)
            save_cnt <= save_cnt + 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            idle_cnt <= '0;
        else if (mode != MODE_OPER || low_edge)
            idle_cnt <= '0;
        else if (idle_cnt < IDLE_TIMEOUT_CYC)
            idle_cnt <= idle_cnt + 1'b1;
    end

    // ----------------------------------------
    // Supply and reference controls
    // ----------------------------------------
    // Startup generator: on in startup and shutdown, hysteresis in save, off when operating.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hv_startup_gen <= 1'b1;
        else
        begin
            case (next_mode)
                MODE_STARTUP, MODE_SHUTDOWN:
                    hv_startup_gen <= 1'b1;
                MODE_SAVE:
                begin
                    if (mode != MODE_SAVE || pins[IN_TURN_ON])
                        hv_startup_gen <= 1'b0;
                    else if (pins[IN_SAVE_LOW])
                        hv_startup_gen <= 1'b1;
                end
                default:
                    hv_startup_gen <= 1'b0;
            endcase
        end
    end

    // Reference source and pin sink; the sink is on whenever the source is off.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ref_enable       <= 1'b0;
            ref_high_current <= 1'b0;
            ref_sink_enable  <= 1'b1;
        end
        else
        begin
            ref_enable       <= (next_mode != MODE_STARTUP) && !pins[IN_REF_OFF];
            ref_sink_enable  <= (next_mode == MODE_STARTUP) || pins[IN_REF_OFF];
            ref_high_current <= (next_mode == MODE_OPER) && !pins[IN_REF_OFF];
        end
    end

    // Two-point regulator switch, only active while operating.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            regulator_switch <= 1'b0;
        else if (next_mode != MODE_OPER)
            regulator_switch <= 1'b0;
        else if (pins[IN_REG_START])
            regulator_switch <= 1'b1;
        else if (low_fall && pins[IN_REG_ON])
            regulator_switch <= 1'b1;
        else if (low_fall && pins[IN_REG_OFF])
            regulator_switch <= 1'b0;
    end

    // ----------------------------------------
    // Overcurrent latch and drivers
    // ----------------------------------------
    // fault latch, set wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fault <= 1'b0;
        else if (mode == MODE_OPER && pins[IN_CS_TRIP])
            fault <= 1'b1;
        else if (!pins[IN_LOW] && !pins[IN_HIGH] && !pins[IN_CS_TRIP])
            fault <= 1'b0;
    end

    assign overcurrent_flag_out = fault;

    // enable, trip and interlock
    // A trip blocks the half-bridge gates in the same edge that sets the fault latch.
    assign drv_en   = (next_mode == MODE_OPER) && !inhibit;
    assign hb_block = fault || (mode == MODE_OPER && pins[IN_CS_TRIP]) || (pins[IN_LOW] && pins[IN_HIGH]);

    // Registered gate outputs.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            low_side_gate_out  <= 1'b0;
            high_side_gate_out <= 1'b0;
            pfc_gate_out       <= 1'b0;
            aux_gate_out       <= 1'b0;
        end
        else
        begin
            low_side_gate_out  <= drv_en && !hb_block && pins[IN_LOW];
            high_side_gate_out <= drv_en && !hb_block && pins[IN_HIGH];
            pfc_gate_out       <= drv_en && pins[IN_PFC];
            aux_gate_out       <= drv_en && pins[IN_AUX];
        end
    end

    assign bootstrap_switch = low_side_gate_out;

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    // Register index of a byte address; 2'd3 marks an unmapped address.
    function automatic logic [1:0] reg_sel(input logic [31:0] addr);
        if (addr[31:4] != '0)
            reg_sel = 2'd3;
        else if (addr[3:0] == ADDR_CTRL)
            reg_sel = 2'd0;
        else if (addr[3:0] == ADDR_STATUS)
            reg_sel = 2'd1;
        else
            reg_sel = 2'd3;
    endfunction

    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = !w_got && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Write channels are captured in either order; the write lands when both are held.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            aw_addr      <= '0;
            w_data       <= '0;
            w_strb       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            inhibit      <= CTRL_INHIBIT_RST;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got  <= 1'b1;
                aw_addr <= (reg_sel(s_axi_awaddr) == 2'd3) ? 4'hF : s_axi_awaddr[3:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_got && w_got)
            begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (reg_sel({28'h0, aw_addr}) == 2'd3) ? RESP_DECERR : RESP_OKAY;
                if (reg_sel({28'h0, aw_addr}) == 2'd0 && w_strb[0])
                    inhibit <= w_data[CTRL_INHIBIT_BIT];
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Read path; status shows mode, fault and regulator switch.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                2'd0:    s_axi_rdata <= {31'h0, inhibit};
                2'd1:    s_axi_rdata <= {28'h0, regulator_switch, fault, 2'(mode)};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_DECERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_trip;
        mode == MODE_OPER && pins[IN_CS_TRIP];
    endsequence
    sequence s_gates_low;
        !low_side_gate_out && !high_side_gate_out && overcurrent_flag_out;
    endsequence

    property p_startup_quiet;
        mode == MODE_STARTUP && $past(mode) == MODE_STARTUP |-> hv_startup_gen && ref_sink_enable
            && !regulator_switch && !low_side_gate_out && !pfc_gate_out && !aux_gate_out;
    endproperty
    a_startup_quiet: assert property (p_startup_quiet) else $error("startup outputs wrong");
    property p_turn_on;
        mode == MODE_STARTUP && pins[IN_TURN_ON] |=> mode == MODE_SAVE && !hv_startup_gen;
    endproperty
    a_turn_on: assert property (p_turn_on) else $error("turn-on did not reach save");
    property p_dwell;
        mode == MODE_SAVE ##1 mode == MODE_OPER |-> $past(save_cnt) >= SAVE_DWELL_CYC;
    endproperty
    a_dwell: assert property (p_dwell) else $error("operating entered too early");
    property p_idle;
        mode == MODE_OPER && idle_cnt == IDLE_TIMEOUT_CYC && !pins[IN_TURN_OFF] && !pins[IN_REF_LOW]
            |=> mode == MODE_SAVE;
    endproperty
    a_idle: assert property (p_idle) else $error("idle timeout missed");
    property p_shutdown;
        mode == MODE_OPER && (pins[IN_TURN_OFF] || pins[IN_REF_LOW]) |=> mode == MODE_SHUTDOWN;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not entered");
    property p_reg_start;
        next_mode == MODE_OPER && pins[IN_REG_START] |=> regulator_switch;
    endproperty
    a_reg_start: assert property (p_reg_start) else $error("regulator switch not closed");
    property p_ref_off;
        pins[IN_REF_OFF] |=> !ref_enable && ref_sink_enable;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("reference on below threshold");
    property p_trip;
        s_trip |=> s_gates_low;
    endproperty
    a_trip: assert property (p_trip) else $error("overcurrent not latched");
    property p_interlock;
        pins[IN_LOW] && pins[IN_HIGH] |=> !low_side_gate_out && !high_side_gate_out;
    endproperty
    a_interlock: assert property (p_interlock) else $error("cross conduction allowed");
    property p_follow;
        next_mode == MODE_OPER && !inhibit && !hb_block |=> low_side_gate_out == $past(pins[IN_LOW])
            && pfc_gate_out == $past(pins[IN_PFC]);
    endproperty
    a_follow: assert property (p_follow) else $error("gate does not follow input");

endmodule // led_pmu_seq

// [bench/mcu_model.sv]
// Behavioural controller that drives the half-bridge logic inputs.
`timescale 1ns/100ps
module mcu_model
(
    input  wire logic aclk,
    input  wire logic run,
    input  wire logic both,
    input  wire logic lo,
    input  wire logic hi,
    output      logic low_in,
    output      logic high_in
);
    logic [3:0] cnt = 4'h0;
    logic       ph  = 1'h0;

    // Free-running phase gives complementary switching every 16 cycles.
    always_ff @(posedge aclk)
    begin
        cnt <= cnt + 4'h1;
        if (cnt == 4'hF)
            ph <= ~ph;
    end

    // no overlap
    // Both inputs go high together only when the bench asks for it.
    always_comb
    begin
        low_in = run ? ph : lo;
        high_in = run ? ~ph : hi && (!lo || both);
    end
endmodule // mcu_model

// [bench/tb.sv]
// Self-checking bench for the LED supply mode sequencer.
`timescale 1ns/100ps
module tb;
    import pmu_seq_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic awready, wready, bvalid, arready, rvalid, lin, hin, hv, ren, rhc, snk, sw, flag, lg, hg, pg, ag, bs;
    logic [1:0] bresp, rresp;
    logic ton = 0, roff = 0, toff = 0, rst = 0, ok = 0, trip = 0, run = 0, both = 0, lo = 0, hi = 0;
    logic pfc = 0, aux = 0, slow = 0, ron = 0, regoff = 0, rlow = 0;
    logic [31:0] p;
    logic [33:0] exp_q[$];
    int error_cnt = 0, checks_done = 0;
    wire [7:0] outs = {hv, ren, rhc, snk, lg, hg, pg, ag};

    // Free-running 25 MHz clock.
    always #20 aclk = ~aclk;

    mcu_model mcu (.aclk(aclk), .run(run), .both(both), .lo(lo), .hi(hi), .low_in(lin), .high_in(hin));

    led_pmu_seq dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .supply_turn_on_thr(ton),
        .supply_save_low_thr(slow), .supply_ref_off_thr(roff), .supply_turn_off_thr(toff),
        .regulator_start_thr(rst), .regulator_on_thr(ron), .regulator_off_thr(regoff),
        .ref_above_enable(ok), .ref_below_latch(rlow), .current_sense_trip(trip),
        .low_side_logic_in(lin), .high_side_logic_in(hin), .pfc_logic_in(pfc), .aux_logic_in(aux),
        .hv_startup_gen(hv), .ref_enable(ren), .ref_high_current(rhc), .ref_sink_enable(snk),
        .regulator_switch(sw), .overcurrent_flag_out(flag), .low_side_gate_out(lg),
        .high_side_gate_out(hg), .pfc_gate_out(pg), .aux_gate_out(ag), .bootstrap_switch(bs));

    task compare(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Write with both channels offered together; response noted for the watcher.
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ad, wd;
        ad = 0;
        wd = 0;
        exp_q.push_back({er, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (awvalid && awready)
            begin
                ad = 1;
                awvalid <= 0;
            end
            if (wvalid && wready)
            begin
                wd = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 0;
        @(posedge aclk);
    endtask

    task rd(input logic [31:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        rready <= 0;
        @(posedge aclk);
    endtask

    function logic [33:0] st(input mode_e m, input logic f, input logic s);
        return {RESP_OKAY, 28'h0, s, f, m};
    endfunction

    task close_out;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watcher: every bus answer is compared with the oldest note.
    always @(posedge aclk)
    begin
        if (rvalid && rready)
            compare({rresp, rdata}, exp_q.pop_front());
        if (bvalid && bready)
            compare({bresp, 32'h0}, exp_q.pop_front());
    end

    // Watchdog cuts a hang short.
    initial
    begin
        #400000;
        error_cnt++;
        close_out;
    end

    // Main sequence.
    initial
    begin
        void'($urandom(36604));
        cyc(10);
        aresetn <= 1;
        lo <= 1;
        pfc <= 1;
        aux <= 1;
        cyc(5);
        compare(outs, 8'h90);
        rd(32'(ADDR_STATUS), st(MODE_STARTUP, 0, 0));
        wr(32'h8, 32'h0, RESP_DECERR);
        rd(32'h8, {RESP_DECERR, 32'h0});
        wr(32'(ADDR_STATUS), 32'hF, RESP_OKAY);
        wr(32'(ADDR_CTRL), 32'h1, RESP_OKAY);
        rd(32'(ADDR_CTRL), {RESP_OKAY, 32'h1});
        wr(32'(ADDR_CTRL), 32'h0, RESP_OKAY);
        ton <= 1;
        lo <= 0;
        cyc(5);
        compare(outs, 8'h40);
        ton <= 0;
        slow <= 1;
        cyc(5);
        compare(outs, 8'hC0);
        slow <= 0;
        ton <= 1;
        cyc(5);
        compare(outs, 8'h40);
        ok <= 1;
        run <= 1;
        cyc(100);
        rd(32'(ADDR_STATUS), st(MODE_SAVE, 0, 0));
        cyc(250);
        rd(32'(ADDR_STATUS), st(MODE_OPER, 0, 0));
        compare(outs[7:4], 4'h6);
        run <= 0;
        for (int i = 0; i < 4; i++)
        begin
            p = $urandom;
            lo <= i[0];
            hi <= i[1];
            both <= i[0] & i[1];
            pfc <= p[0];
            aux <= p[1];
            cyc(5);
            compare(outs, {4'h6, i[0] & !i[1], i[1] & !i[0], p[0], p[1]});
            compare(bs, i[0] & !i[1]);
        end
        rst <= 1;
        cyc(5);
        compare(sw, 1);
        rst <= 0;
        lo <= 1;
        hi <= 0;
        both <= 0;
        trip <= 1;
        cyc(5);
        compare({flag, lg}, 2'h2);
        trip <= 0;
        cyc(5);
        compare(flag, 1);
        lo <= 0;
        cyc(5);
        compare(flag, 0);
        regoff <= 1;
        lo <= 1;
        cyc(5);
        compare(sw, 1);
        lo <= 0;
        cyc(5);
        compare(sw, 0);
        regoff <= 0;
        ron <= 1;
        lo <= 1;
        cyc(5);
        compare(sw, 0);
        lo <= 0;
        cyc(5);
        compare(sw, 1);
        ron <= 0;
        cyc(1700);
        rd(32'(ADDR_STATUS), st(MODE_OPER, 0, 1));
        cyc(1500);
        rd(32'(ADDR_STATUS), st(MODE_SAVE, 0, 0));
        run <= 1;
        cyc(300);
        ton <= 0;
        toff <= 1;
        cyc(5);
        compare(outs, 8'hC0);
        toff <= 0;
        ton <= 1;
        cyc(5);
        compare(outs, 8'h40);
        cyc(320);
        ton <= 0;
        rlow <= 1;
        cyc(5);
        compare(outs, 8'hC0);
        rlow <= 0;
        ton <= 1;
        cyc(5);
        ton <= 0;
        roff <= 1;
        cyc(5);
        compare(outs, 8'h90);
        close_out;
    end
endmodule // tb
